// ==== src/gpio_port_params.svh ====
// Constants for the port data and pin-set register block.
// Assumes byte addressing on a 32-bit APB with aligned words.
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_PORT0_PIN_SET    32'hffff0d24
`define ADDR_PORT1_PIN_SET    32'hffff0d34
`define ADDR_PORT2_DIR_OUT_IN 32'hffff0d40

// ==========================================================
// Port2 direction bits
`define P2_DIR6 30
`define P2_DIR5 29
`define P2_DIR4 28
`define P2_DIR1 25
`define P2_DIR0 24
// Port2 output value bits
`define P2_OUT6 22
`define P2_OUT5 21
`define P2_OUT1 17
`define P2_OUT0 16
// Port2 input status bits
`define P2_IN6 6
`define P2_IN5 5
`define P2_IN4 4
`define P2_IN1 1
`define P2_IN0 0
// Bits that read back anything at all
`define P2_RD_MASK 32'h7363_0073

// ==========================================================
// Set register fields
`define P0_SET_HI 20
`define P0_SET_LO 16
`define P1_SET_HI 17
`define P1_SET_LO 16

// ==========================================================
// Reset values
`define P2_DIR_RESET 5'h00
`define P2_VAL_RESET 4'h0
`define P0_VAL_RESET 5'h00
`define P1_VAL_RESET 2'h0
`define RDATA_RESET  32'h0000_0000

`endif

// ==== src/gpio_port_pkg.sv ====
// Types shared by the port register block and its helpers.
// Assumes gpio_port_params.svh supplies the numeric constants.
package gpio_port_pkg;

  // ==========================================================
  // Register selected by an APB address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_P0SET,
    SEL_P1SET,
    SEL_P2DAT
  } reg_sel_t;

  // Pin vectors: port2 pins ordered {6,5,4,1,0}
  typedef logic [4:0] port2_vec_t;

endpackage

// ==== src/pin_sync_if.sv ====
// Carrier between the register block and its pin synchroniser.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 5);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface // pin_sync_if

// ==== src/pin_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels.
// Assumes raw levels may change at any time against core_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic   core_clk, // System clock
  input  wire logic   reset,    // Async reset, active high
  pin_sync_if.sync    bus       // Raw in, synced out
);
  import gpio_port_pkg::*;

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // ==========================================================
  // Double flop; stage1 is read by stage2 only (metastability)
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= bus.raw;
      stage2_reg <= stage1_reg;
    end
  end

  assign bus.synced = stage2_reg;
endmodule // pin_sync

// ==== src/gpio_port_regs.sv ====
// APB slave holding the port2 data register and the port0/port1
// pin-set registers, with the pin drivers they steer.
// Assumes a single core_clk domain; pin inputs are asynchronous.
// Functional notes
// - Port2 data word is 32 bits
// - Bit 30 sets pin6 direction
// - Bit 29 sets pin5 direction
// - Bit 28 sets pin4 direction
// - Bits 25, 24 set pin1, pin0 direction
// - Bits 22, 21 drive pins 6, 5
// - Bits 17, 16 drive pins 1, 0
// - Bits 6, 5, 4 read pin levels
// - Bits 1, 0 read pin levels
// - Port0 set bits 20..16 raise pins
// - Writing zero to set bit changes nothing
// - Only pins written as one change
// - Port1 set register is write-only
// - Port1 set bits 17, 16 raise pins
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "gpio_port_params.svh"
module gpio_port_regs (
  input  wire logic                     core_clk,     // System clock
  input  wire logic                     reset,        // Async reset, high
  input  wire logic                     psel,         // APB select
  input  wire logic                     penable,      // APB enable
  input  wire logic                     pwrite,       // APB direction
  input  wire logic [31:0]              paddr,        // APB byte address
  input  wire logic [31:0]              pwdata,       // APB write data
  output logic      [31:0]              prdata,       // APB read data
  output logic                          pready,       // APB ready
  output logic                          pslverr,      // APB error
  input  wire gpio_port_pkg::port2_vec_t port2PinIn,  // Port2 pin levels
  output logic [4:0]                    port2PinOut,  // Port2 drive value
  output logic [4:0]                    port2PinOe,   // Port2 drive enable
  input  wire logic [4:0]               port0Dir,     // Port0 directions
  output logic [4:0]                    port0PinOut,  // Port0 drive value
  output logic [4:0]                    port0PinOe,   // Port0 drive enable
  input  wire logic [1:0]               port1Dir,     // Port1 directions
  output logic [1:0]                    port1PinOut,  // Port1 drive value
  output logic [1:0]                    port1PinOe    // Port1 drive enable
);
  import gpio_port_pkg::*;

  // ==========================================================
  // Declarations
  reg_sel_t    sel;
  logic        accessDone_reg;
  logic        wrFire;
  logic        rdLoad;
  logic [31:0] prdata_reg;
  logic [31:0] rdValue;
  logic [4:0]  p2Dir_reg;   // {6,5,4,1,0}
  logic [3:0]  p2Val_reg;   // {6,5,1,0}
  logic [4:0]  p0Val_reg;
  logic [1:0]  p1Val_reg;
  logic [4:0]  p0SetBits;
  logic [1:0]  p1SetBits;
  port2_vec_t  p2Synced;

  // ==========================================================
  // Address decode, shared by read and write paths
  function automatic reg_sel_t decodeAddr(input logic [31:0] addr);
    reg_sel_t s;
    s = SEL_NONE;
    case (addr)
      `ADDR_PORT0_PIN_SET:    s = SEL_P0SET;
      `ADDR_PORT1_PIN_SET:    s = SEL_P1SET;
      `ADDR_PORT2_DIR_OUT_IN: s = SEL_P2DAT;
      default:                s = SEL_NONE;
    endcase
    return s;
  endfunction

  assign sel = decodeAddr(paddr);

  // ==========================================================
  // Pin input synchroniser
  pin_sync_if #(.WIDTH(5)) syncBus ();

  assign syncBus.raw = port2PinIn;
  assign p2Synced    = syncBus.synced;

  pin_sync #(
    .WIDTH    (5)
  ) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .bus      (syncBus)
  );

  // ==========================================================
  // APB handshake: one wait cycle so read data comes from a flop
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      accessDone_reg <= 1'b0;
    else if (psel && penable && !accessDone_reg)
      accessDone_reg <= 1'b1;
    else
      accessDone_reg <= 1'b0;
  end

  assign pready  = accessDone_reg;
  assign pslverr = pready && psel && penable && (sel == SEL_NONE);
  assign wrFire  = psel && penable && pready && pwrite && (sel != SEL_NONE);
  assign rdLoad  = psel && penable && !pready && !pwrite;

  // ==========================================================
  // Read mux; set registers are write-only and read as zero
  always_comb
  begin
    rdValue = '0;
    case (sel)
      SEL_P2DAT:
      begin
        rdValue[`P2_DIR6] = p2Dir_reg[4];
        rdValue[`P2_DIR5] = p2Dir_reg[3];
        rdValue[`P2_DIR4] = p2Dir_reg[2];
        rdValue[`P2_DIR1] = p2Dir_reg[1];
        rdValue[`P2_DIR0] = p2Dir_reg[0];
        rdValue[`P2_OUT6] = p2Val_reg[3];
        rdValue[`P2_OUT5] = p2Val_reg[2];
        rdValue[`P2_OUT1] = p2Val_reg[1];
        rdValue[`P2_OUT0] = p2Val_reg[0];
        rdValue[`P2_IN6]  = p2Synced[4];
        rdValue[`P2_IN5]  = p2Synced[3];
        rdValue[`P2_IN4]  = p2Synced[2];
        rdValue[`P2_IN1]  = p2Synced[1];
        rdValue[`P2_IN0]  = p2Synced[0];
      end
      default:
        rdValue = '0;
    endcase
  end

  // Read data captured in the wait cycle, held until next load
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      prdata_reg <= `RDATA_RESET;
    else if (rdLoad)
      prdata_reg <= rdValue;
  end

  assign prdata = prdata_reg;

  // ==========================================================
  // Port2 direction; written bits of input status are ignored
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      p2Dir_reg <= `P2_DIR_RESET;
    else if (wrFire && sel == SEL_P2DAT)
    begin
      p2Dir_reg[4] <= pwdata[`P2_DIR6];
      p2Dir_reg[3] <= pwdata[`P2_DIR5];
      p2Dir_reg[2] <= pwdata[`P2_DIR4];
      p2Dir_reg[1] <= pwdata[`P2_DIR1];
      p2Dir_reg[0] <= pwdata[`P2_DIR0];
    end
  end

  // Port2 output values
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      p2Val_reg <= `P2_VAL_RESET;
    else if (wrFire && sel == SEL_P2DAT)
    begin
      p2Val_reg[3] <= pwdata[`P2_OUT6];
      p2Val_reg[2] <= pwdata[`P2_OUT5];
      p2Val_reg[1] <= pwdata[`P2_OUT1];
      p2Val_reg[0] <= pwdata[`P2_OUT0];
    end
  end

  // ==========================================================
  // Set registers: OR in the ones, zeros leave pins alone
  assign p0SetBits = pwdata[`P0_SET_HI:`P0_SET_LO];
  assign p1SetBits = pwdata[`P1_SET_HI:`P1_SET_LO];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      p0Val_reg <= `P0_VAL_RESET;
    else if (wrFire && sel == SEL_P0SET)
      p0Val_reg <= p0Val_reg | p0SetBits;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      p1Val_reg <= `P1_VAL_RESET;
    else if (wrFire && sel == SEL_P1SET)
      p1Val_reg <= p1Val_reg | p1SetBits;
  end

  // ==========================================================
  // Pin drivers; pin4 has no value bit so it drives low
  assign port2PinOut = {p2Val_reg[3:2], 1'b0, p2Val_reg[1:0]};
  assign port2PinOe  = p2Dir_reg;
  assign port0PinOut = p0Val_reg;
  assign port0PinOe  = port0Dir;
  assign port1PinOut = p1Val_reg;
  assign port1PinOe  = port1Dir;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_p2Write;
    wrFire && sel == SEL_P2DAT;
  endsequence

  sequence s_p2ReadLoad;
    rdLoad && sel == SEL_P2DAT;
  endsequence

  sequence s_p0Set;
    wrFire && sel == SEL_P0SET;
  endsequence

  sequence s_p1Set;
    wrFire && sel == SEL_P1SET;
  endsequence

  property p_dirWrite;
    s_p2Write |=> port2PinOe == {$past(pwdata[`P2_DIR6]), $past(pwdata[`P2_DIR5]),
      $past(pwdata[`P2_DIR4]), $past(pwdata[`P2_DIR1]), $past(pwdata[`P2_DIR0])};
  endproperty
  a_dirWrite: assert property (p_dirWrite)
    else $error("port2 direction not taken from write");

  property p_outWrite;
    s_p2Write |=> port2PinOut == {$past(pwdata[`P2_OUT6]), $past(pwdata[`P2_OUT5]),
      1'b0, $past(pwdata[`P2_OUT1]), $past(pwdata[`P2_OUT0])};
  endproperty
  a_outWrite: assert property (p_outWrite)
    else $error("port2 output value not driven from write");

  property p_inRead;
    s_p2ReadLoad |=> prdata[6:4] == $past(p2Synced[4:2])
      && prdata[1:0] == $past(p2Synced[1:0]);
  endproperty
  a_inRead: assert property (p_inRead)
    else $error("port2 input status wrong on read");

  property p_p2Reserved;
    s_p2ReadLoad ##1 pready |-> (prdata & ~`P2_RD_MASK) == 32'h0000_0000;
  endproperty
  a_p2Reserved: assert property (p_p2Reserved)
    else $error("port2 reserved bits not zero");

  property p_p0SetRaises;
    s_p0Set |=> (port0PinOut & $past(p0SetBits)) == $past(p0SetBits);
  endproperty
  a_p0SetRaises: assert property (p_p0SetRaises)
    else $error("port0 set bit did not raise value");

  property p_p0SetKeeps;
    s_p0Set |=> (port0PinOut & ~$past(p0SetBits))
      == ($past(port0PinOut) & ~$past(p0SetBits));
  endproperty
  a_p0SetKeeps: assert property (p_p0SetKeeps)
    else $error("port0 unset pin changed");

  property p_p1Set;
    s_p1Set |=> port1PinOut == ($past(port1PinOut) | $past(p1SetBits));
  endproperty
  a_p1Set: assert property (p_p1Set)
    else $error("port1 set write wrong");

  property p_setReadsZero;
    (rdLoad && (sel == SEL_P0SET || sel == SEL_P1SET)) ##1 pready
      |-> prdata == 32'h0000_0000;
  endproperty
  a_setReadsZero: assert property (p_setReadsZero)
    else $error("write-only set register read nonzero");

  property p_setToPin;
    (s_p0Set and (pwdata[`P0_SET_LO] && port0Dir[0])) ##1 port0Dir[0]
      |-> port0PinOut[0] && port0PinOe[0];
  endproperty
  a_setToPin: assert property (p_setToPin)
    else $error("set bit did not reach output pin");

  property p_readyOneWait;
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_readyOneWait: assert property (p_readyOneWait)
    else $error("pready timing wrong");

  // Hold checks: nothing moves unless its own write lands
  property p_dirHold;
    !(wrFire && sel == SEL_P2DAT) |=> $stable(port2PinOe);
  endproperty
  a_dirHold: assert property (p_dirHold)
    else $error("port2 direction changed without a write");

  property p_valHold;
    !(wrFire && sel == SEL_P2DAT) |=> $stable(port2PinOut);
  endproperty
  a_valHold: assert property (p_valHold)
    else $error("port2 output value changed without a write");

  property p_p0Hold;
    !(wrFire && sel == SEL_P0SET) |=> $stable(port0PinOut);
  endproperty
  a_p0Hold: assert property (p_p0Hold)
    else $error("port0 value changed without a set write");

  property p_p1Hold;
    !(wrFire && sel == SEL_P1SET) |=> $stable(port1PinOut);
  endproperty
  a_p1Hold: assert property (p_p1Hold)
    else $error("port1 value changed without a set write");

  // Read data must stand until the next load
  property p_readHold;
    !rdLoad |=> $stable(prdata);
  endproperty
  a_readHold: assert property (p_readHold)
    else $error("read data moved without a read");

  // Status path is exactly two flops; skipped while reset history is fresh
  property p_syncDelay;
    (!$past(reset) && !$past(reset, 2)) |-> p2Synced == $past(port2PinIn, 2);
  endproperty
  a_syncDelay: assert property (p_syncDelay)
    else $error("pin status not two cycles behind pin");

  // A write to an unmapped place must not touch any state
  property p_unmappedIgnored;
    (psel && penable && pready && pwrite && sel == SEL_NONE)
      |=> $stable(p2Dir_reg) && $stable(p2Val_reg)
      && $stable(p0Val_reg) && $stable(p1Val_reg);
  endproperty
  a_unmappedIgnored: assert property (p_unmappedIgnored)
    else $error("unmapped write changed state");

  property p_errOnlyUnmapped;
    (psel && penable && pready) |-> pslverr == (sel == SEL_NONE);
  endproperty
  a_errOnlyUnmapped: assert property (p_errOnlyUnmapped)
    else $error("error response on wrong address");

endmodule // gpio_port_regs

// ==== verification/pin_model.sv ====
// Behavioural model of the port2 pins outside the block.
// Assumes each pin is pushed by the block while enabled, else by the world.
`timescale 1ns/1ps
module pin_model (
  input  wire logic [4:0]              port2PinOut, // Block drive value
  input  wire logic [4:0]              port2PinOe,  // Block drive enable
  input  wire logic [4:0]              extLevel,    // Level the world applies
  output gpio_port_pkg::port2_vec_t    port2PinIn   // Level seen on the pin
);
  import gpio_port_pkg::*;
  // ==========================================================
  // Pin resolution
  // Our driver wins while enabled; the world is ignored then
  assign port2PinIn = (port2PinOe & port2PinOut) | (~port2PinOe & extLevel);
endmodule // pin_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the port2 data and port0/port1 pin-set registers.
// Assumes an APB slave with one wait state and a pin model beside it.
`timescale 1ns/1ps
`include "gpio_port_params.svh"
module tb_top;
  import gpio_port_pkg::*;
  typedef struct packed {
    logic [31:0] wd;
    logic [4:0]  ext;
    logic [4:0]  oe;
    logic [4:0]  out;
    logic [31:0] rd;
  } row_t;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] wd;
    logic [4:0]  p0;
    logic [1:0]  p1;
  } set_t;
  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] paddr    = 32'h0;
  logic [31:0] pwdata   = 32'h0;
  logic [4:0]  extLevel = 5'h00;
  logic [4:0]  port0Dir = 5'h0b;
  logic [1:0]  port1Dir = 2'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  port2_vec_t  port2PinIn;
  logic [4:0]  port2PinOut;
  logic [4:0]  port2PinOe;
  logic [4:0]  port0PinOut;
  logic [4:0]  port0PinOe;
  logic [1:0]  port1PinOut;
  logic [1:0]  port1PinOe;
  logic [31:0] rd;
  logic        err;
  int          errorCnt = 0;
  int          cmpCount = 0;
  // Rows: writes keep reserved and status bits zero
  row_t rows[5] = '{
    '{32'h0000_0000, 5'h15, 5'h00, 5'h00, 32'h0000_0051},
    '{32'h7363_0000, 5'h00, 5'h1f, 5'h1b, 32'h7363_0063},
    '{32'h4020_0000, 5'h0a, 5'h10, 5'h08, 32'h4020_0022},
    '{32'h1100_0000, 5'h1f, 5'h05, 5'h00, 32'h1100_0062},
    '{32'h2203_0000, 5'h00, 5'h0a, 5'h03, 32'h2203_0002}};
  set_t sets[7] = '{
    '{`ADDR_PORT0_PIN_SET, 32'h0001_0000, 5'h01, 2'h0},
    '{`ADDR_PORT0_PIN_SET, 32'h0014_0000, 5'h15, 2'h0},
    '{`ADDR_PORT0_PIN_SET, 32'h0000_0000, 5'h15, 2'h0},
    '{`ADDR_PORT1_PIN_SET, 32'h0002_0000, 5'h15, 2'h2},
    '{`ADDR_PORT1_PIN_SET, 32'h0000_0000, 5'h15, 2'h2},
    '{`ADDR_PORT1_PIN_SET, 32'h0001_0000, 5'h15, 2'h3},
    '{`ADDR_PORT0_PIN_SET, 32'h001f_0000, 5'h1f, 2'h3}};

  // ==========================================================
  // Clock, design and pin model
  always #4 core_clk = ~core_clk;

  gpio_port_regs dut (
    .core_clk    (core_clk),
    .reset       (reset),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .port2PinIn  (port2PinIn),
    .port2PinOut (port2PinOut),
    .port2PinOe  (port2PinOe),
    .port0Dir    (port0Dir),
    .port0PinOut (port0PinOut),
    .port0PinOe  (port0PinOe),
    .port1Dir    (port1Dir),
    .port1PinOut (port1PinOut),
    .port1PinOe  (port1PinOe)
  );

  pin_model pins (
    .port2PinOut (port2PinOut),
    .port2PinOe  (port2PinOe),
    .extLevel    (extLevel),
    .port2PinIn  (port2PinIn)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  // Only the watchdog ends a wait that never gets an answer
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never raises psel in this step
    @(posedge core_clk);
  endtask

  task automatic finishTest();
    $display("comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #(8 * 5000);
    errorCnt++;
    finishTest();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk(32'(port2PinOe), 32'h0);
    chk(32'(port0PinOe), 32'h0000_000b);
    chk(prdata, 32'h0);
    $display("reset values done");
    // Direction, output value and pin readback per row
    foreach (rows[i])
    begin
      extLevel <= rows[i].ext;
      apb(1'b1, `ADDR_PORT2_DIR_OUT_IN, rows[i].wd);
      repeat (3) @(posedge core_clk);
      chk(32'(port2PinOe), 32'(rows[i].oe));
      chk(32'(port2PinOut), 32'(rows[i].out));
      apb(1'b0, `ADDR_PORT2_DIR_OUT_IN, 32'h0);
      chk(rd, rows[i].rd);
    end
    $display("port2 rows done");
    // All ones written: only the mapped bits may take
    apb(1'b1, `ADDR_PORT2_DIR_OUT_IN, 32'hffff_ffff);
    repeat (3) @(posedge core_clk);
    chk(32'(port2PinOe), 32'h1f);
    chk(32'(port2PinOut), 32'h1b);
    apb(1'b0, `ADDR_PORT2_DIR_OUT_IN, 32'h0);
    chk(rd, 32'h7363_0063);
    $display("all-ones write done");
    // Pin-set writes only ever raise the pins written as one
    foreach (sets[i])
    begin
      apb(1'b1, sets[i].a, sets[i].wd);
      @(posedge core_clk);
      chk(32'(port0PinOut), 32'(sets[i].p0));
      chk(32'(port1PinOut), 32'(sets[i].p1));
    end
    chk(32'(port1PinOe), 32'h1);
    // Output enables follow the outside direction levels
    port0Dir <= 5'h14;
    port1Dir <= 2'h2;
    @(posedge core_clk);
    chk(32'(port0PinOe), 32'h14);
    chk(32'(port1PinOe), 32'h2);
    $display("pin-set rows done");
    // Port0 set register reads as zero in bits 31..1; an unmapped place errors
    apb(1'b0, `ADDR_PORT0_PIN_SET, 32'h0);
    chk({rd[31:1], err}, 32'h0);
    apb(1'b1, 32'hffff_0d30, 32'h0000_0000);
    chk(32'(err), 32'h1);
    apb(1'b0, `ADDR_PORT2_DIR_OUT_IN, 32'h0);
    chk(rd, 32'h7363_0063);
    $display("access checks done");
    // Reset in mid-run clears the port2 drivers
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'({port2PinOe, port2PinOut}), 32'h0);
    reset <= 1'b0;
    extLevel <= 5'h1f;
    repeat (3) @(posedge core_clk);
    apb(1'b0, `ADDR_PORT2_DIR_OUT_IN, 32'h0);
    chk(rd, 32'h0000_0073);
    // Ones outside the set fields raise nothing
    apb(1'b1, `ADDR_PORT0_PIN_SET, 32'hffe0_ffff);
    @(posedge core_clk);
    chk(32'(port0PinOut), 32'h0);
    apb(1'b1, `ADDR_PORT1_PIN_SET, 32'hfffc_ffff);
    @(posedge core_clk);
    chk(32'(port1PinOut), 32'h0);
    $display("second reset done");
    finishTest();
  end
endmodule // tb_top
